// ===== hw/afe_regs_pkg.sv
// Package for the smoke front-end control register bank.
// Assumes a 32-bit AXI4-Lite master with word-aligned accesses.
package afe_regs_pkg;
    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_REGS = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] IDX_SWITCH = 3'h0;
    localparam logic [IDX_W-1:0] IDX_INCAP = 3'h1;
    localparam logic [IDX_W-1:0] IDX_GAIN0 = 3'h2;
    localparam logic [IDX_W-1:0] IDX_GAIN1 = 3'h3;
    localparam logic [IDX_W-1:0] IDX_CTRL0 = 3'h4;
    localparam logic [IDX_W-1:0] IDX_CTRL1 = 3'h5;
    localparam logic [IDX_W-1:0] IDX_TRIM0 = 3'h6;
    localparam logic [IDX_W-1:0] IDX_TRIM1 = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Writable masks and reset values
    // ************************************************************
    localparam logic [REG_W-1:0] MASK_SWITCH = 8'hFF;
    localparam logic [REG_W-1:0] MASK_INCAP = 8'hB1;
    localparam logic [REG_W-1:0] MASK_GAIN0 = 8'h3F;
    localparam logic [REG_W-1:0] MASK_GAIN1 = 8'hFF;
    localparam logic [REG_W-1:0] MASK_CTRL = 8'h43;
    localparam logic [REG_W-1:0] MASK_TRIM = 8'hFF;
    localparam logic [REG_W-1:0] RST_SWITCH = 8'h80;
    localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RST_TRIM = 8'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_SW7 = 7;
    localparam int BIT_SW4 = 4;
    localparam int BIT_SW3 = 3;
    localparam int BIT_SW2 = 2;
    localparam int BIT_SW1 = 1;
    localparam int BIT_SW0 = 0;
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 5;
    localparam int BIT_PIS = 7;
    localparam int CAP0_HI = 5;
    localparam int CAP0_LO = 4;
    localparam int BIT_CAP1 = 0;
    localparam int CODE_HI = 5;
    localparam int R3_HI = 7;
    localparam int R3_LO = 6;
    localparam int BIT_EN = 6;
    localparam int BIT_STAT = 5;
    localparam int BW_HI = 1;
    localparam int BIT_CAL = 7;
    localparam int BIT_RSP = 6;

    // Coupling mode decode
    typedef enum logic [1:0] {
        MODE_EXT0 = 2'h0,
        MODE_AC = 2'h1,
        MODE_EXT1 = 2'h2,
        MODE_DC = 2'h3
    } couple_type;
endpackage : afe_regs_pkg

// ===== hw/smoke_afe_control_regs.sv
// Register bank steering the two-amplifier smoke front end.
// Assumes an AXI4-Lite master on clock; status pins are asynchronous analog comparator levels.
// Analog switching itself happens outside this file.
`timescale 1ns/1ps

module smoke_afe_control_regs (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clockEnable,

    // AXI4-Lite write address and data
    input wire logic [afe_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [afe_regs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,

    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,

    // AXI4-Lite read
    input wire logic [afe_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [afe_regs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    // Analog switch controls
    output logic switch_bit7,
    output logic switch_bit4,
    output logic switch_bit3,
    output logic switch_bit2,
    output logic switch_bit1,
    output logic switch_bit0,
    output logic [1:0] coupling_mode_field,
    output logic couplingExternal,
    output logic couplingAc,
    output logic couplingDc,

    // Input and capacitor selects
    output logic amp0_pos_input_select,
    output logic [1:0] amp0_cap_select,
    output logic amp1_cap_select,

    // Resistor codes
    output logic [5:0] amp0_first_resistor_code,
    output logic [1:0] amp1_third_resistor_code,
    output logic [5:0] amp1_second_resistor_code,

    // Amplifier controls
    output logic amp0_enable,
    output logic amp1_enable,
    output logic [1:0] amp0_bandwidth_select,
    output logic [1:0] amp1_bandwidth_select,
    output logic amp0_calibration_mode,
    output logic amp1_calibration_mode,
    output logic amp0_cal_reference_select,
    output logic amp1_cal_reference_select,
    output logic [5:0] amp0_trim_value,
    output logic [5:0] amp1_trim_value,

    // Raw comparator levels from the amplifiers
    input wire logic amp0OutputRaw,
    input wire logic amp1OutputRaw
);
    import afe_regs_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        // Register images
        logic [REG_W-1:0] swCtrl;
        logic [REG_W-1:0] inCap;
        logic [REG_W-1:0] gain0;
        logic [REG_W-1:0] gain1;
        logic [REG_W-1:0] ctrl0;
        logic [REG_W-1:0] ctrl1;
        logic [REG_W-1:0] trim0;
        logic [REG_W-1:0] trim1;
        // Status synchronisers
        logic [1:0] syncA;
        logic [1:0] syncB;
        // Write channel
        logic awHeld;
        logic [IDX_W-1:0] awIdx;
        logic awBad;
        logic wHeld;
        logic [REG_W-1:0] wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        // Read channel
        logic rValid;
        logic [DATA_W-1:0] rData;
        logic [1:0] rResp;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    // Word index from the address, used on both channels
    function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] a);
        return a[IDX_LSB +: IDX_W];
    endfunction : regIndex

    // Sub-word addresses get an error response
    function automatic logic badAddr(input logic [ADDR_W-1:0] a);
        return a[IDX_LSB-1:0] != '0;
    endfunction : badAddr

    // Merge under a writable mask so reserved bits stay zero
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] d, input logic [REG_W-1:0] m);
        return d & m;
    endfunction : merge

    // ************************************************************
    // Read view
    // ************************************************************
    logic [REG_W-1:0] readView [NUM_REGS];
    logic stat0;
    logic stat1;

    // Status is forced low outside calibration mode
    // Calibration bit lives in the trim register
    assign stat0 = state_r.syncA[1] & state_r.trim0[BIT_CAL];
    assign stat1 = state_r.syncB[1] & state_r.trim1[BIT_CAL];

    always_comb begin
        readView[IDX_SWITCH] = state_r.swCtrl;
        readView[IDX_INCAP] = state_r.inCap & MASK_INCAP;
        readView[IDX_GAIN0] = state_r.gain0 & MASK_GAIN0;
        readView[IDX_GAIN1] = state_r.gain1;
        readView[IDX_CTRL0] = (state_r.ctrl0 & MASK_CTRL) | (REG_W'(stat0) << BIT_STAT);
        readView[IDX_CTRL1] = (state_r.ctrl1 & MASK_CTRL) | (REG_W'(stat1) << BIT_STAT);
        readView[IDX_TRIM0] = state_r.trim0;
        readView[IDX_TRIM1] = state_r.trim1;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    logic doWrite;
    logic doRead;

    // Write commits once both halves are held and the response slot is free
    assign doWrite = state_r.awHeld & state_r.wHeld & ~state_r.bValid;
    assign doRead = s_axi_arvalid & ~state_r.rValid;

    always_comb begin
        state_nxt = state_r;
        // Two-flop synchronisers; only the second stage is read
        state_nxt.syncA = {state_r.syncA[0], amp0OutputRaw};
        state_nxt.syncB = {state_r.syncB[0], amp1OutputRaw};

        // Capture address and data independently
        if (s_axi_awvalid && s_axi_awready) begin
            state_nxt.awHeld = 1'b1;
            state_nxt.awIdx = regIndex(s_axi_awaddr);
            state_nxt.awBad = badAddr(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_nxt.wHeld = 1'b1;
            state_nxt.wData = s_axi_wdata[REG_W-1:0];
            state_nxt.wLane0 = s_axi_wstrb[0];
        end

        if (doWrite) begin
            state_nxt.awHeld = 1'b0;
            state_nxt.wHeld = 1'b0;
            state_nxt.bValid = 1'b1;
            state_nxt.bResp = state_r.awBad ? RESP_SLVERR : RESP_OKAY;
            // Only byte lane 0 carries register bits; upper lanes are ignored
            if (!state_r.awBad && state_r.wLane0) begin
                unique case (state_r.awIdx)
                    IDX_SWITCH: state_nxt.swCtrl = merge(state_r.wData, MASK_SWITCH);
                    IDX_INCAP: state_nxt.inCap = merge(state_r.wData, MASK_INCAP);
                    IDX_GAIN0: state_nxt.gain0 = merge(state_r.wData, MASK_GAIN0);
                    IDX_GAIN1: state_nxt.gain1 = merge(state_r.wData, MASK_GAIN1);
                    IDX_CTRL0: state_nxt.ctrl0 = merge(state_r.wData, MASK_CTRL);
                    IDX_CTRL1: state_nxt.ctrl1 = merge(state_r.wData, MASK_CTRL);
                    IDX_TRIM0: state_nxt.trim0 = merge(state_r.wData, MASK_TRIM);
                    IDX_TRIM1: state_nxt.trim1 = merge(state_r.wData, MASK_TRIM);
                endcase
            end
        end

        // Response drains on bready
        if (state_r.bValid && s_axi_bready) begin
            state_nxt.bValid = 1'b0;
        end

        // Reads answer one cycle after the address is taken
        if (doRead) begin
            state_nxt.rValid = 1'b1;
            state_nxt.rData = {{(DATA_W-REG_W){1'b0}}, readView[regIndex(s_axi_araddr)]};
            state_nxt.rResp = badAddr(s_axi_araddr) ? RESP_SLVERR : RESP_OKAY;
            if (badAddr(s_axi_araddr)) begin
                state_nxt.rData = '0;
            end
        end else if (state_r.rValid && s_axi_rready) begin
            state_nxt.rValid = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Synchronous reset; clock enable freezes everything
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            // Non-zero defaults follow the clear
            state_r <= '0;
            state_r.swCtrl <= RST_SWITCH;
            state_r.inCap <= RST_ZERO;
            state_r.gain0 <= RST_ZERO;
            state_r.gain1 <= RST_ZERO;
            state_r.ctrl0 <= RST_ZERO;
            state_r.ctrl1 <= RST_ZERO;
            state_r.trim0 <= RST_TRIM;
            state_r.trim1 <= RST_TRIM;
        end else if (clockEnable) begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Bus outputs
    // ************************************************************
    // Ready is held low while a frozen clock could miss a handshake
    assign s_axi_awready = ~state_r.awHeld & clockEnable;
    assign s_axi_wready = ~state_r.wHeld & clockEnable;
    assign s_axi_arready = ~state_r.rValid & clockEnable;

    // Answers come straight from flops
    assign s_axi_bvalid = state_r.bValid;
    assign s_axi_bresp = state_r.bResp;
    assign s_axi_rvalid = state_r.rValid;
    assign s_axi_rdata = state_r.rData;
    assign s_axi_rresp = state_r.rResp;

    // ************************************************************
    // Analog controls
    // ************************************************************
    // Switch 1 is not gated in DC mode; keeping it off is software's job
    assign switch_bit7 = state_r.swCtrl[BIT_SW7];
    assign switch_bit4 = state_r.swCtrl[BIT_SW4];
    assign switch_bit3 = state_r.swCtrl[BIT_SW3];
    assign switch_bit2 = state_r.swCtrl[BIT_SW2];
    assign switch_bit1 = state_r.swCtrl[BIT_SW1];
    assign switch_bit0 = state_r.swCtrl[BIT_SW0];
    assign coupling_mode_field = state_r.swCtrl[MODE_HI:MODE_LO];

    // Both external codes decode alike
    assign couplingExternal = (coupling_mode_field == MODE_EXT0) || (coupling_mode_field == MODE_EXT1);
    assign couplingAc = coupling_mode_field == MODE_AC;
    assign couplingDc = coupling_mode_field == MODE_DC;

    // Input and capacitor selects
    assign amp0_pos_input_select = state_r.inCap[BIT_PIS];
    assign amp0_cap_select = state_r.inCap[CAP0_HI:CAP0_LO];
    assign amp1_cap_select = state_r.inCap[BIT_CAP1];

    // Resistor codes
    assign amp0_first_resistor_code = state_r.gain0[CODE_HI:0];
    assign amp1_third_resistor_code = state_r.gain1[R3_HI:R3_LO];
    assign amp1_second_resistor_code = state_r.gain1[CODE_HI:0];

    // Bandwidth choice versus converter clock is left to software
    assign amp0_enable = state_r.ctrl0[BIT_EN];
    assign amp1_enable = state_r.ctrl1[BIT_EN];
    assign amp0_bandwidth_select = state_r.ctrl0[BW_HI:0];
    assign amp1_bandwidth_select = state_r.ctrl1[BW_HI:0];

    // Calibration controls
    assign amp0_calibration_mode = state_r.trim0[BIT_CAL];
    assign amp1_calibration_mode = state_r.trim1[BIT_CAL];
    assign amp0_cal_reference_select = state_r.trim0[BIT_RSP];
    assign amp1_cal_reference_select = state_r.trim1[BIT_RSP];

    // Trim search runs in software against the status bit
    assign amp0_trim_value = state_r.trim0[CODE_HI:0];
    assign amp1_trim_value = state_r.trim1[CODE_HI:0];

    // ************************************************************
    // Assertions
    // ************************************************************
    // Status, reserved bits, error reads and sync depth
    a_status_gated: assert property (@(posedge clock) disable iff (!reset_n)
        !state_r.trim0[BIT_CAL] |-> !readView[IDX_CTRL0][BIT_STAT])
        else $error("status visible outside calibration");

    a_status1_gated: assert property (@(posedge clock) disable iff (!reset_n)
        !amp1_calibration_mode |-> !readView[IDX_CTRL1][BIT_STAT])
        else $error("status 1 visible outside calibration");

    a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_rvalid |-> s_axi_rdata[DATA_W-1:REG_W] == '0)
        else $error("upper read bits not zero");

    a_ctrl_reserved: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r.ctrl0 & ~MASK_CTRL) == '0 && (state_r.inCap & ~MASK_INCAP) == '0)
        else $error("reserved bit stored");

    a_bad_read: assert property (@(posedge clock) disable iff (!reset_n)
        clockEnable && doRead && badAddr(s_axi_araddr) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("misaligned read not refused");

    a_sync_delay: assert property (@(posedge clock) disable iff (!reset_n)
        clockEnable [*3] |-> state_r.syncA[1] == $past(amp0OutputRaw, 2))
        else $error("synchroniser depth wrong");

    // Reset values and register writes
    a_reset_values: assert property (@(posedge clock)
        $rose(reset_n) |-> !amp0_enable && !amp1_calibration_mode && amp1_trim_value == RST_TRIM[CODE_HI:0])
        else $error("reset values wrong");

    a_enable_follow: assert property (@(posedge clock) disable iff (!reset_n)
        clockEnable && doWrite && state_r.awIdx == IDX_CTRL1 && !state_r.awBad && state_r.wLane0
        |=> amp1_enable == $past(state_r.wData[BIT_EN]))
        else $error("enable not written");

    a_trim_write: assert property (@(posedge clock) disable iff (!reset_n)
        clockEnable && doWrite && state_r.awIdx == IDX_TRIM0 && !state_r.awBad && state_r.wLane0
        |=> amp0_trim_value == $past(state_r.wData[CODE_HI:0]))
        else $error("trim not written");

    // Coupling and switches
    a_mode_decode: assert property (@(posedge clock) disable iff (!reset_n)
        $onehot({couplingExternal, couplingAc, couplingDc}) && (couplingDc == (coupling_mode_field == 2'h3)))
        else $error("coupling decode wrong");

    a_switch_map: assert property (@(posedge clock) disable iff (!reset_n)
        {switch_bit7, switch_bit4, switch_bit0} == {state_r.swCtrl[7], state_r.swCtrl[4], state_r.swCtrl[0]})
        else $error("switch mapping wrong");

    // Bus timing
    a_read_latency: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    // Main scenarios reached
    c_write_done: cover property (@(posedge clock) disable iff (!reset_n) s_axi_bvalid && s_axi_bready);
    c_read_done: cover property (@(posedge clock) disable iff (!reset_n) s_axi_rvalid && s_axi_rready);
    c_cal_status: cover property (@(posedge clock) disable iff (!reset_n) stat0 || stat1);
    c_dc_mode: cover property (@(posedge clock) disable iff (!reset_n) couplingDc);
endmodule : smoke_afe_control_regs

// ===== test/afe_analog_model.sv
// Behavioural amplifier pair: comparator level seen by the register bank.
// Assumes trim, enable and calibration levels come straight from the bank.
`timescale 1ns/1ps
module afe_analog_model #(
    parameter int THRESH0 = 23,
    parameter int THRESH1 = 41,
    parameter int LAT = 1
) (
    // Clock
    input wire logic clock,
    // Register levels
    input wire logic [1:0] ampEnable,
    input wire logic [1:0] calMode,
    input wire logic [5:0] trim0,
    input wire logic [5:0] trim1,
    // Comparator outputs
    output logic amp0OutputRaw,
    output logic amp1OutputRaw
);
    logic [1:0] levelNow;
    logic [7:0] histR = 8'h00;
    logic [9:0] histAll;
    // In calibration the output flips where trim crosses the offset; else sensor follows enable
    always_comb begin
        levelNow[0] = calMode[0] ? (int'(trim0) >= THRESH0) : ampEnable[0];
        levelNow[1] = calMode[1] ? (int'(trim1) >= THRESH1) : ampEnable[1];
    end
    // Settling lag of the analog path, so the bank cannot rely on an instant answer
    always @(posedge clock) begin
        histR <= histAll[7:0];
    end
    assign histAll = {histR, levelNow};
    assign amp0OutputRaw = histAll[2*LAT];
    assign amp1OutputRaw = histAll[2*LAT+1];
endmodule : afe_analog_model

// ===== test/smoke_afe_control_regs_tb.sv
// Self-checking bench for the front-end register bank over AXI4-Lite.
// Assumes the analog model answers calibration reads after its lag plus two sync flops.
`timescale 1ns/1ps
module smoke_afe_control_regs_tb;
    import afe_regs_pkg::*;
    localparam int TH0 = 23;
    localparam int TH1 = 41;
    logic clock = 1'b0, reset_n = 1'b0, clockEnable = 1'b1;
    logic [ADDR_W-1:0] awAddr = '0, arAddr = '0;
    logic awValid = 1'b0, awReady, wValid = 1'b0, wReady, bValid, bReady = 1'b0;
    logic arValid = 1'b0, arReady, rValid, rReady = 1'b0;
    logic [31:0] wData = '0, rData;
    logic [3:0] wStrb = '0;
    logic [1:0] bResp, rResp, cplField, cap0, code3, bw0, bw1, ampEnable, calMode, refSel;
    logic [5:0] swBits, code0, code2, trim0, trim1;
    logic cplExt, cplAc, cplDc, posSel, cap1, raw0, raw1;
    int errCount = 0, checksDone = 0;

    smoke_afe_control_regs i_dut (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .switch_bit7(swBits[5]), .switch_bit4(swBits[4]), .switch_bit3(swBits[3]),
        .switch_bit2(swBits[2]), .switch_bit1(swBits[1]), .switch_bit0(swBits[0]),
        .coupling_mode_field(cplField), .couplingExternal(cplExt), .couplingAc(cplAc), .couplingDc(cplDc),
        .amp0_pos_input_select(posSel), .amp0_cap_select(cap0), .amp1_cap_select(cap1),
        .amp0_first_resistor_code(code0), .amp1_third_resistor_code(code3), .amp1_second_resistor_code(code2),
        .amp0_enable(ampEnable[0]), .amp1_enable(ampEnable[1]), .amp0_bandwidth_select(bw0),
        .amp1_bandwidth_select(bw1), .amp0_calibration_mode(calMode[0]), .amp1_calibration_mode(calMode[1]),
        .amp0_cal_reference_select(refSel[0]), .amp1_cal_reference_select(refSel[1]),
        .amp0_trim_value(trim0), .amp1_trim_value(trim1), .amp0OutputRaw(raw0), .amp1OutputRaw(raw1));
    afe_analog_model #(.THRESH0(TH0), .THRESH1(TH1), .LAT(1)) i_model (.clock(clock), .ampEnable(ampEnable),
        .calMode(calMode), .trim0(trim0), .trim1(trim1), .amp0OutputRaw(raw0), .amp1OutputRaw(raw1));

    // ********************************************
    // Clock, verdict and watchdog
    // ********************************************
    always #2 clock = ~clock;
    task automatic printVerdict();
        $display("Checks %0d, mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : printVerdict
    // Far above the few thousand cycles the sequence needs
    initial begin
        repeat (40000) @(posedge clock);
        errCount++;
        printVerdict();
    end

    // ********************************************
    // Bus tasks and comparison
    // ********************************************
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : expect_eq
    // Ready is sampled in the low phase, where it already holds its value for the coming edge
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic awHit, wHit, bHit;
        @(posedge clock);
        awAddr <= a; awValid <= 1'b1; wData <= {24'hFFFFFF, d}; wStrb <= s; wValid <= 1'b1; bReady <= 1'b1;
        bHit = 1'b0;
        while (!bHit) begin
            @(negedge clock);
            awHit = awValid & awReady; wHit = wValid & wReady; bHit = bValid & bReady; r = bResp;
            @(posedge clock);
            if (awHit) awValid <= 1'b0;
            if (wHit) wValid <= 1'b0;
            if (bHit) bReady <= 1'b0;
        end
    endtask : axi_write
    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic arHit, rHit;
        @(posedge clock);
        arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
        rHit = 1'b0;
        while (!rHit) begin
            @(negedge clock);
            arHit = arValid & arReady; rHit = rValid & rReady; d = rData; r = rResp;
            @(posedge clock);
            if (arHit) arValid <= 1'b0;
            if (rHit) rReady <= 1'b0;
        end
    endtask : axi_read
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_write({idx, 2'b00}, d, 4'hF, r);
        expect_eq({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : wr
    task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read({idx, 2'b00}, d, r);
        expect_eq({r, d}, {RESP_OKAY, 24'h0, exp});
    endtask : rd

    // ********************************************
    // Scenarios
    // ********************************************
    task automatic test_reset();
        logic [7:0] rst [8] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20};
        for (int i = 0; i < 8; i++) rd(3'(i), rst[i]);
        expect_eq({26'h0, swBits}, 32'h20);
        expect_eq({ampEnable, calMode, trim0, trim1}, {4'h0, 12'h820});
    endtask : test_reset
    task automatic test_masks();
        logic [7:0] exp [8] = '{8'hFD, 8'hB1, 8'h3F, 8'hFF, 8'h63, 8'h63, 8'hFF, 8'hFF};
        for (int i = 0; i < 6; i++) wr(3'(i), i ? 8'hFF : 8'hFD); // switch 1 kept off in DC
        rd(IDX_CTRL0, 8'h43);
        rd(IDX_CTRL1, 8'h43);
        wr(IDX_TRIM0, 8'hFF);
        wr(IDX_TRIM1, 8'hFF);
        repeat (4) @(posedge clock);
        for (int i = 0; i < 8; i++) rd(3'(i), exp[i]);
    endtask : test_masks
    task automatic test_switch();
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            d = {m[0], m[1:0], m[1], ~m[0], m[0], ~m[1], m[1]}; // switch 1 stays off in DC
            wr(IDX_SWITCH, d);
            expect_eq({swBits, cplField}, {d[7], d[4:0], m[1:0]});
            expect_eq({cplExt, cplAc, cplDc}, {m[0] == 0, m == 1, m == 3});
        end
    endtask : test_switch
    task automatic test_fields();
        wr(IDX_INCAP, 8'hA1);
        expect_eq({posSel, cap0, cap1}, 4'hD);
        wr(IDX_INCAP, 8'h5E);
        expect_eq({posSel, cap0, cap1}, 4'h2);
        wr(IDX_GAIN0, 8'hEA);
        expect_eq(code0, 6'h2A);
        wr(IDX_GAIN1, 8'hC5);
        expect_eq({code3, code2}, {2'h3, 6'h05});
        wr(IDX_GAIN1, 8'h3A);
        expect_eq({code3, code2}, {2'h0, 6'h3A});
        for (int b = 0; b < 4; b++) begin
            wr(IDX_CTRL0, {1'b1, b[0], 4'hF, b[1:0]});
            wr(IDX_CTRL1, {1'b1, ~b[0], 4'hF, ~b[1:0]}); // no converter clock runs here
            expect_eq({ampEnable, bw0, bw1}, {~b[0], b[0], b[1:0], ~b[1:0]});
        end
    endtask : test_fields
    task automatic calibrate(input int amp, input int th);
        logic [IDX_W-1:0] tIdx, cIdx;
        logic [31:0] d;
        logic [1:0] r;
        logic first;
        int v1, v2;
        tIdx = amp ? IDX_TRIM1 : IDX_TRIM0;
        cIdx = amp ? IDX_CTRL1 : IDX_CTRL0;
        wr(cIdx, 8'h40);
        wr(tIdx, 8'hC0); // search upward from zero
        expect_eq({calMode[amp], refSel[amp]}, 2'h3);
        repeat (4) @(posedge clock);
        axi_read({cIdx, 2'b00}, d, r);
        first = d[5];
        v1 = 0;
        for (int t = 1; t < 64 && v1 == 0; t++) begin
            wr(tIdx, {2'h3, 6'(t)});
            repeat (4) @(posedge clock);
            axi_read({cIdx, 2'b00}, d, r);
            if (d[5] !== first) v1 = t;
        end
        expect_eq(v1, th);
        wr(tIdx, 8'hFF); // then downward from all ones
        repeat (4) @(posedge clock);
        axi_read({cIdx, 2'b00}, d, r);
        first = d[5];
        v2 = 0;
        for (int t = 62; t >= 0 && v2 == 0; t--) begin
            wr(tIdx, {2'h3, 6'(t)});
            repeat (4) @(posedge clock);
            axi_read({cIdx, 2'b00}, d, r);
            if (d[5] !== first) v2 = t;
        end
        expect_eq(v2, th - 1);
        wr(tIdx, {2'h0, 6'((v1 + v2) / 2)}); // truncated average
        repeat (4) @(posedge clock);
        rd(cIdx, 8'h40);
        expect_eq({calMode[amp], amp ? trim1 : trim0}, {1'b0, 6'(th - 1)});
    endtask : calibrate
    task automatic test_errors();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(5'h01, 8'h00, 4'hF, r);
        expect_eq({r, swBits}, {RESP_SLVERR, 6'h35});
        axi_read(5'h06, d, r);
        expect_eq({r, d}, {RESP_SLVERR, 32'h0});
        axi_write({IDX_GAIN0, 2'b00}, 8'h11, 4'h0, r);
        expect_eq({30'h0, r}, {30'h0, RESP_OKAY});
        rd(IDX_GAIN0, 8'h2A);
        clockEnable <= 1'b0;
        fork
            wr(IDX_GAIN1, 8'h77);
            begin
                repeat (6) @(posedge clock);
                expect_eq({awReady, code2}, {1'b0, 6'h3A});
                clockEnable <= 1'b1;
            end
        join
        expect_eq({code3, code2}, {2'h1, 6'h37});
    endtask : test_errors

    // ********************************************
    // Main sequence, with a second reset before the final reset check
    // ********************************************
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        test_reset();
        test_masks();
        test_switch();
        test_fields();
        calibrate(0, TH0);
        calibrate(1, TH1);
        test_errors();
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        test_reset();
        printVerdict();
    end
endmodule : smoke_afe_control_regs_tb
